// ==== hdl/flash_divider.sv ====
/*
 * Divides the master clock into a square wave of 50 percent duty.
 * Assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/10ps

module flash_divider #(
    parameter int HALF_CYCLES = 12500000  // Cycles per half period
) (
    input  wire logic hclk,     // Master clock
    input  wire logic hresetn,  // Asynchronous reset, active low
    output logic      blink     // Square wave
);

    localparam int CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] count;  // Cycles into the current half period

    // ------------------------------------------------------------------
    // Half-period counter and toggle
    // ------------------------------------------------------------------
    // [RL14] equal halves from clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            blink <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            blink <= ~blink;
        end else begin
            count <= count + 1'b1;
        end
    end

    // Toggle exactly at the end of each half period
    a_flash_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // [RL14]
        (count == LAST) |=> (blink != $past(blink)))
        else $error("flash divider missed its toggle");

    a_flash_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RL14]
        (count != LAST) |=> $stable(blink))
        else $error("flash divider toggled early");

endmodule : flash_divider

// ==== hdl/lamp_params.svh ====
/*
 * Constants of the status lamp and overhead-bit block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by bare name wherever these macros are used.
 */
`ifndef LAMP_PARAMS_SVH
`define LAMP_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define LAMP_CLK_HZ          25000000
`define LAMP_SLOW_FLASH_HZ   1
`define LAMP_FAST_FLASH_HZ   8
`define LAMP_RESYNC_MS       96
// Half period of a flash pattern, in clock cycles
`define LAMP_HALF_CYCLES(hz) (`LAMP_CLK_HZ / (2 * (hz)))
// Hold-off after loss of S/T synchronization, in clock cycles
`define LAMP_RESYNC_CYCLES   ((`LAMP_CLK_HZ / 1000) * `LAMP_RESYNC_MS)

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LAMP_OFS_CFS         8'h00
`define LAMP_OFS_GCR1        8'h04
`define LAMP_OFS_INT_STATUS  8'h08
`define LAMP_OFS_INT_MASK    8'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LAMP_CFS_U_SYNC      0
`define LAMP_CFS_ST_SYNC     1
`define LAMP_CFS_ACTIVE      2
`define LAMP_CFS_UOA         3
`define LAMP_CFS_AIB         6
`define LAMP_GCR1_PS2        0
`define LAMP_GCR1_PS1        1
`define LAMP_GCR1_SAI_LO     6
`define LAMP_GCR1_SAI_HI     7
`define LAMP_INT_AIB_CHG     0
`define LAMP_INT_UOA_CHG     1
`define LAMP_INT_ST_LOST     2
`define LAMP_INT_U_SYNC      3
`define LAMP_INT_BITS        4

// ----------------------------------------------------------------------
// Reset values and the sai force code
// ----------------------------------------------------------------------
`define LAMP_RST_GCR1        8'h03
`define LAMP_RST_AIB         1'b1
`define LAMP_RST_UOA         1'b0
`define LAMP_SAI_FORCE_ONE   2'h1

`endif

// ==== hdl/lamp_pkg.sv ====
/*
 * Types shared by the status lamp block.
 * Assumes nothing of its surroundings.
 */
package lamp_pkg;

    // ------------------------------------------------------------------
    // Lamp pattern states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        LAMP_DARK = 4'h1,  // Nothing happening, lamp off
        LAMP_FAST = 4'h2,  // 8 Hz flashing, U problem or start-up
        LAMP_SLOW = 4'h4,  // 1 Hz flashing, U synchronized
        LAMP_ON   = 4'h8   // Steady on, fully active
    } lamp_state_t;

endpackage : lamp_pkg

// ==== hdl/nt_status_lamp.sv ====
/*
 * Status lamp and U overhead-bit logic of the network termination, with
 * an AHB-Lite register slave and a level interrupt.
 * Assumes: inputs synchronous to hclk; rx_bits_valid pulses once per
 * received overhead set; single AHB-Lite master, word transfers only.
 */
// Our own choices: the AHB-Lite slave port and the address map.
// Function
// [RL1] Wait 96 ms after S/T sync loss
// [RL2] S/T sync toggles lamp 1 Hz/steady on
// [RL3] U start-up attempt gives 8 Hz flashing
// [RL4] 8 Hz flashing marks U-side trouble
// [RL5] U synchronized gives 1 Hz flashing
// [RL6] Full activation drives lamp steady low
// [RL7] aib zero keeps 8 Hz flashing
// [RL8] Received aib readable at status bit 6
// [RL9] Default sai follows S/T activity
// [RL10] Control 0,1 forces sai to one
// [RL11] Send ps1, ps2 as configured
// [RL12] uoa zero keeps S/T silent
// [RL13] Received uoa readable at status bit 3
// [RL14] Flash rates divided, 50 percent duty
// [RL15] Pattern chosen each cycle, gated steady-on
`timescale 1ns/10ps
`include "lamp_params.svh"

module nt_status_lamp #(
    parameter int SLOW_HALF = `LAMP_HALF_CYCLES(`LAMP_SLOW_FLASH_HZ),  // 1 Hz half
    parameter int FAST_HALF = `LAMP_HALF_CYCLES(`LAMP_FAST_FLASH_HZ),  // 8 Hz half
    parameter int RESYNC    = `LAMP_RESYNC_CYCLES                      // 96 ms
) (
    input  wire logic        hclk,             // Master clock, 25 MHz
    input  wire logic        hresetn,          // Asynchronous reset, active low
    input  wire logic        hsel,             // Slave select
    input  wire logic [31:0] haddr,            // Byte address
    input  wire logic [1:0]  htrans,           // Transfer type
    input  wire logic        hwrite,           // Write when high
    input  wire logic [2:0]  hsize,            // Transfer size, word only
    input  wire logic [31:0] hwdata,           // Write data
    input  wire logic        hready,           // Bus ready
    output logic             hreadyout,        // Slave ready
    output logic [31:0]      hrdata,           // Read data
    output logic             hresp,            // Response, always OKAY
    input  wire logic        u_startup_seen,   // Start-up attempt on U
    input  wire logic        u_synced,         // U-interface synchronized
    input  wire logic        u_fully_active,   // Link active end to end
    input  wire logic        st_sync_detect,   // S/T framing found
    input  wire logic        rx_bits_valid,    // Pulse, new overhead bits
    input  wire logic        rx_aib,           // Received alarm indication
    input  wire logic        rx_uoa,           // Received U-only activation
    output logic             st_status_lamp_n, // Lamp, low is on
    output logic             st_synced,        // S/T synchronized
    output logic             st_info_enable,   // S/T may send INFO 1/2
    output logic             tx_sai,           // Upstream S/T activity
    output logic             tx_ps1,           // Upstream power status 1
    output logic             tx_ps2,           // Upstream power status 2
    output logic             irq               // Interrupt, active high
);
    import lamp_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic        blink_slow;        // 1 Hz square wave
    logic        blink_fast;        // 8 Hz square wave
    logic        holdoff_busy;      // Resync hold-off running
    logic        st_lost;           // Pulse, S/T sync just lost
    logic        aib;               // Latest received aib
    logic        uoa;               // Latest received uoa
    logic        u_synced_q;        // U sync, one cycle late
    logic [7:0]  general_control_reg_one;  // sai control and power bits
    logic [`LAMP_INT_BITS-1:0] int_status; // Sticky events
    logic [`LAMP_INT_BITS-1:0] int_mask;   // Interrupt enables
    logic [`LAMP_INT_BITS-1:0] int_set;    // Events this cycle
    logic [`LAMP_INT_BITS-1:0] int_clr;    // Write-one-to-clear bits
    logic [7:0]  control_flow_status_reg;  // Readable state
    logic        wr_pend;           // Write in data phase
    logic [7:0]  wr_addr;           // Address of pending write
    logic        addr_ok;           // Address phase accepted
    lamp_state_t state;             // Current lamp pattern
    lamp_state_t next_state;        // Pattern for next cycle

    // ------------------------------------------------------------------
    // Flash pattern sources
    // ------------------------------------------------------------------
    flash_divider #(
        .HALF_CYCLES (SLOW_HALF)
    ) u_slow (
        .hclk    (hclk),
        .hresetn (hresetn),
        .blink   (blink_slow)
    );

    flash_divider #(
        .HALF_CYCLES (FAST_HALF)
    ) u_fast (
        .hclk    (hclk),
        .hresetn (hresetn),
        .blink   (blink_fast)
    );

    // ------------------------------------------------------------------
    // S/T synchronization with resync hold-off
    // ------------------------------------------------------------------
    // Loss seen while synchronized starts the hold-off
    assign st_lost = st_synced && !st_sync_detect;

    resync_timer #(
        .CYCLES (RESYNC)
    ) u_resync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (st_lost),
        .busy    (holdoff_busy)
    );

    // [RL1] no reacquire during hold-off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_synced <= 1'b0;
        end else if (st_lost) begin
            st_synced <= 1'b0;
        end else if (st_sync_detect && !holdoff_busy && !st_lost) begin
            st_synced <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Received overhead bits
    // ------------------------------------------------------------------
    // [RL8] latch received aib
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aib <= `LAMP_RST_AIB;
        end else if (rx_bits_valid) begin
            aib <= rx_aib;
        end
    end

    // [RL13] latch received uoa
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uoa <= `LAMP_RST_UOA;
        end else if (rx_bits_valid) begin
            uoa <= rx_uoa;
        end
    end

    // [RL12] S/T quiet while uoa low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_info_enable <= 1'b0;
        end else begin
            st_info_enable <= u_synced && uoa;
        end
    end

    // ------------------------------------------------------------------
    // Upstream overhead bits
    // ------------------------------------------------------------------
    // [RL9] [RL10] sai follow or force
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_sai <= 1'b0;
        end else if (general_control_reg_one[`LAMP_GCR1_SAI_HI:`LAMP_GCR1_SAI_LO]
                     == `LAMP_SAI_FORCE_ONE) begin
            tx_sai <= 1'b1;
        end else begin
            tx_sai <= st_synced;
        end
    end

    // [RL11] power status as set
    assign tx_ps1 = general_control_reg_one[`LAMP_GCR1_PS1];
    assign tx_ps2 = general_control_reg_one[`LAMP_GCR1_PS2];

    // ------------------------------------------------------------------
    // Lamp pattern selection
    // ------------------------------------------------------------------
    // [RL15] next pattern from inputs each cycle
    always_comb begin
        if (u_fully_active && !aib) begin
            // [RL7] alarm keeps fast flash
            next_state = LAMP_FAST;
        end else if (u_fully_active && st_synced) begin
            // [RL6] steady on when active
            next_state = LAMP_ON;
        end else if (u_synced) begin
            // [RL5] [RL2] U synced, slow flash
            next_state = LAMP_SLOW;
        end else if (u_startup_seen) begin
            // [RL3] [RL4] start-up fast flash
            next_state = LAMP_FAST;
        end else begin
            next_state = LAMP_DARK;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= LAMP_DARK;
        end else begin
            state <= next_state;
        end
    end

    // Lamp driver, low means lit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_status_lamp_n <= 1'b1;
        end else begin
            case (state)
                LAMP_ON:   st_status_lamp_n <= 1'b0;
                LAMP_SLOW: st_status_lamp_n <= ~blink_slow;
                LAMP_FAST: st_status_lamp_n <= ~blink_fast;
                LAMP_DARK: st_status_lamp_n <= 1'b1;
                default:   st_status_lamp_n <= 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    // U sync history for the rising-edge event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            u_synced_q <= 1'b0;
        end else begin
            u_synced_q <= u_synced;
        end
    end

    assign int_set[`LAMP_INT_AIB_CHG] = rx_bits_valid && (rx_aib != aib);
    assign int_set[`LAMP_INT_UOA_CHG] = rx_bits_valid && (rx_uoa != uoa);
    assign int_set[`LAMP_INT_ST_LOST] = st_lost;
    assign int_set[`LAMP_INT_U_SYNC]  = u_synced && !u_synced_q;

    // Clear bits from a write to the status register
    assign int_clr = (wr_pend && wr_addr == `LAMP_OFS_INT_STATUS) ?
                     hwdata[`LAMP_INT_BITS-1:0] : '0;

    // Sticky status, a new event wins over a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~int_clr) | int_set;
        end
    end

    assign irq = |(int_status & int_mask);

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    assign control_flow_status_reg = {1'b0, aib, 2'b00, uoa, u_fully_active,
                                      st_synced, u_synced};

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Read data registered at address phase, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                `LAMP_OFS_CFS:        hrdata <= {24'h0, control_flow_status_reg};
                `LAMP_OFS_GCR1:       hrdata <= {24'h0, general_control_reg_one};
                `LAMP_OFS_INT_STATUS: hrdata <= {28'h0, int_status};
                `LAMP_OFS_INT_MASK:   hrdata <= {28'h0, int_mask};
                default:              hrdata <= 32'h0;
            endcase
        end
    end

    // General control register write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            general_control_reg_one <= `LAMP_RST_GCR1;
        end else if (wr_pend && wr_addr == `LAMP_OFS_GCR1) begin
            general_control_reg_one <= hwdata[7:0];
        end
    end

    // Interrupt mask write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask <= '0;
        end else if (wr_pend && wr_addr == `LAMP_OFS_INT_MASK) begin
            int_mask <= hwdata[`LAMP_INT_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_holdoff_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
        st_lost |=> (!st_synced)[*8])
        else $error("S/T sync reacquired inside hold-off");

    a_lamp_steady: assert property (@(posedge hclk) disable iff (!hresetn) // [RL6]
        (state == LAMP_ON) |=> !st_status_lamp_n)
        else $error("lamp not lit in active state");

    a_slow_follow: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
        (state == LAMP_SLOW) |=> (st_status_lamp_n == !$past(blink_slow)))
        else $error("lamp not on slow pattern");

    a_fast_follow: assert property (@(posedge hclk) disable iff (!hresetn) // [RL3]
        (state == LAMP_FAST) |=> (st_status_lamp_n == !$past(blink_fast)))
        else $error("lamp not on fast pattern");

    a_alarm_blocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RL7]
        (u_fully_active && !aib) |=> (state == LAMP_FAST))
        else $error("alarm did not force fast flashing");

    a_on_gated: assert property (@(posedge hclk) disable iff (!hresetn) // [RL15]
        (state == LAMP_ON) |-> $past(aib && st_synced && u_fully_active))
        else $error("steady on without its conditions");

    a_u_sync_slow: assert property (@(posedge hclk) disable iff (!hresetn) // [RL5]
        (u_synced && !u_fully_active) |=> (state == LAMP_SLOW))
        else $error("U sync did not give slow flashing");

    a_aib_latch: assert property (@(posedge hclk) disable iff (!hresetn) // [RL8]
        rx_bits_valid |=> (control_flow_status_reg[`LAMP_CFS_AIB] == $past(rx_aib)))
        else $error("aib status bit not updated");

    a_uoa_latch: assert property (@(posedge hclk) disable iff (!hresetn) // [RL13]
        rx_bits_valid |=> (control_flow_status_reg[`LAMP_CFS_UOA] == $past(rx_uoa)))
        else $error("uoa status bit not updated");

    a_uoa_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // [RL12]
        !uoa |=> !st_info_enable)
        else $error("S/T enabled while uoa is zero");

    a_sai_forced: assert property (@(posedge hclk) disable iff (!hresetn) // [RL10]
        (general_control_reg_one[7:6] == 2'h1) |=> tx_sai)
        else $error("sai not forced to one");

    a_sai_follow: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
        (general_control_reg_one[7:6] == 2'h0) |=> (tx_sai == $past(st_synced)))
        else $error("sai does not follow S/T activity");

    a_ps_bits: assert property (@(posedge hclk) disable iff (!hresetn) // [RL11]
        (wr_pend && wr_addr == `LAMP_OFS_GCR1) |=> (tx_ps1 == $past(hwdata[1])
                                                    && tx_ps2 == $past(hwdata[0])))
        else $error("power status bits not as written");

endmodule : nt_status_lamp

// ==== hdl/resync_timer.sv ====
/*
 * One-shot hold-off timer: busy for a fixed count after a start pulse.
 * Assumes one clock, asynchronous active-low reset.
 */
`timescale 1ns/10ps

module resync_timer #(
    parameter int CYCLES = 2400000  // Hold-off length in cycles
) (
    input  wire logic hclk,     // Master clock
    input  wire logic hresetn,  // Asynchronous reset, active low
    input  wire logic start,    // Pulse, starts or restarts the hold-off
    output logic      busy      // High while hold-off runs
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] remain;  // Cycles left

    // ------------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------------
    // [RL1] resync hold-off count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain <= '0;
        end else if (start) begin
            remain <= LOAD;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign busy = (remain != '0);

    a_timer_start: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
        start |=> (busy && remain == LOAD))
        else $error("hold-off timer did not load");

endmodule : resync_timer

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the status lamp block over AHB-Lite.
 * Assumes short flash and hold-off parameters and a 25 MHz clock.
 */
`timescale 1ns/10ps
module testbench;
    import lamp_pkg::*;
    logic        hclk = 1'b0, hresetn, hsel, hwrite;
    logic        st_sync_detect, hreadyout, hresp, st_status_lamp_n;
    logic        st_synced, st_info_enable, tx_sai, tx_ps1, tx_ps2, irq;
    logic        u_startup_seen, u_synced, u_fully_active, rx_bits_valid, rx_aib, rx_uoa;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          err_total = 0, comparisons = 0;
    always #20 hclk = ~hclk;
    nt_status_lamp #(.SLOW_HALF(8), .FAST_HALF(2), .RESYNC(20)) nt_status_lamp_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .u_startup_seen, .u_synced,
        .u_fully_active, .st_sync_detect, .rx_bits_valid, .rx_aib, .rx_uoa,
        .st_status_lamp_n, .st_synced, .st_info_enable, .tx_sai, .tx_ps1, .tx_ps2, .irq);
    upstream_lt_model upstream_lt_model_i (.hclk, .startup(u_startup_seen),
        .synced(u_synced), .active(u_fully_active), .bits_valid(rx_bits_valid),
        .aib(rx_aib), .uoa(rx_uoa));
    // Compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Counts and verdict
    task test_done;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // Bounded wait for hready at a rising edge
    task rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            if (++n > 50) begin
                err_total++;
                test_done;
            end
            @(posedge hclk);
        end
    endtask : rdy
    // One single word transfer; read data lands in q
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {htrans, hsel, hwrite, hsize, haddr} <= {2'h2, 1'b1, w, 3'h2, 24'h0, a};
        rdy;
        {htrans, hsel, hwdata} <= {2'h0, 1'b0, d};
        rdy;
        q = hrdata;
    endtask : bus
    task rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // Lamp toggles over 32 cycles; bit 8 gives the level when steady
    task lamp(input logic [31:0] exp);
        logic p;
        int   t;
        repeat (4) @(posedge hclk);
        p = st_status_lamp_n;
        t = 0;
        repeat (32) begin
            @(posedge hclk);
            t += int'(st_status_lamp_n !== p);
            p = st_status_lamp_n;
        end
        chk({23'h0, (t == 0) & p, 8'(t)}, exp);
    endtask : lamp
    initial begin
        {hresetn, hsel, hwrite, st_sync_detect, htrans, hsize, haddr, hwdata} <= '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h04, 32'h03);
        rd(8'h00, 32'h40);
        chk(32'({tx_ps1, tx_ps2}), 32'h3);
        chk(32'(hresp), 32'h0);
        lamp(32'h100);
        upstream_lt_model_i.set_link(3'h4);
        lamp(32'h10);
        upstream_lt_model_i.set_link(3'h6);
        lamp(32'h04);
        upstream_lt_model_i.send_bits(1'b1, 1'b1);
        rd(8'h00, 32'h49);
        chk(32'(st_info_enable), 32'h1);
        $display("test start-up done");
        st_sync_detect <= 1'b1;
        upstream_lt_model_i.set_link(3'h7);
        lamp(32'h0);
        chk(32'(tx_sai), 32'h1);
        upstream_lt_model_i.send_bits(1'b0, 1'b1);
        lamp(32'h10);
        rd(8'h00, 32'h0f);
        rd(8'h08, 32'h0b);
        bus(1'b1, 8'h0c, 32'h1);
        @(posedge hclk);
        chk(32'(irq), 32'h1);
        bus(1'b1, 8'h08, 32'h0b);
        @(posedge hclk);
        chk(32'(irq), 32'h0);
        rd(8'h08, 32'h0);
        $display("test alarm done");
        upstream_lt_model_i.send_bits(1'b1, 1'b1);
        st_sync_detect <= 1'b0;
        lamp(32'h04);
        chk(32'(tx_sai), 32'h0);
        st_sync_detect <= 1'b1;
        lamp(32'h0);
        st_sync_detect <= 1'b0;
        repeat (3) @(posedge hclk);
        st_sync_detect <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(32'(st_synced), 32'h0);
        repeat (20) @(posedge hclk);
        chk(32'(st_synced), 32'h1);
        $display("test resync done");
        st_sync_detect <= 1'b0;
        bus(1'b1, 8'h04, 32'h43);
        repeat (2) @(posedge hclk);
        chk(32'(tx_sai), 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h04, 32'(i));
            repeat (2) @(posedge hclk);
            chk(32'({tx_ps1, tx_ps2}), 32'(i));
        end
        chk(32'(tx_sai), 32'h0);
        upstream_lt_model_i.send_bits(1'b1, 1'b0);
        repeat (2) @(posedge hclk);
        chk(32'(st_info_enable), 32'h0);
        rd(8'h08, 32'h07);
        rd(8'h20, 32'h0);
        $display("test overhead bits done");
        test_done;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        test_done;
    end
endmodule : testbench

// ==== tb/upstream_lt_model.sv ====
/*
 * Model of the upstream line termination: U link levels and overhead bits.
 * Assumes the bench calls its tasks just after a rising edge of hclk.
 */
`timescale 1ns/10ps
module upstream_lt_model (
    input  wire logic hclk,       // Master clock
    output logic      startup,    // Start-up attempt on U
    output logic      synced,     // U synchronized
    output logic      active,     // Link active end to end
    output logic      bits_valid, // Overhead strobe, one cycle
    output logic      aib,        // Alarm indication bit
    output logic      uoa         // U-only activation bit
);
    // Quiet line at time zero
    initial begin
        {startup, synced, active, bits_valid, aib, uoa} = 6'h00;
    end
    // Set the U link levels
    task set_link(input logic [2:0] s);
        @(posedge hclk);
        {startup, synced, active} <= s;
    endtask : set_link
    // Send one overhead set; stale bits are inverted after the strobe
    task send_bits(input logic a, input logic u);
        @(posedge hclk);
        {bits_valid, aib, uoa} <= {1'b1, a, u};
        @(posedge hclk);
        {bits_valid, aib, uoa} <= {1'b0, ~a, ~u};
    endtask : send_bits
endmodule : upstream_lt_model
